// ### shared/supervisor_cfg.svh
// Timing constants and encodings for the reset supervisor
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
`define CLK_PERIOD_NS      100
`define DELAY_LONG_MS      200
`define DELAY_SHORT_MS     25
`define TOUT_LONG_MS       1600
`define TOUT_SHORT_MS      200
`define NS_PER_MS          1000000
`define CNT_W              32
`define DELAY_LONG_CYC     ((`DELAY_LONG_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define DELAY_SHORT_CYC    ((`DELAY_SHORT_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define TOUT_LONG_CYC      ((`TOUT_LONG_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define TOUT_SHORT_CYC     ((`TOUT_SHORT_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define CNT_ZERO           32'h0000_0000
`define CNT_ONE            32'h0000_0001
`endif

// ### shared/supervisor_pkg.sv
// Types shared by the reset supervisor modules
package supervisor_pkg;
  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_DELAY   = 2'b01,
    ST_RUN     = 2'b10
  } sup_state_t;
endpackage

// ### logic/sup_counter.sv
// Loadable down counter flagging its last count of one, then holding at zero
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module sup_counter
  import supervisor_pkg::*;
#(
  parameter int W = `CNT_W
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  typedef struct packed
  {
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.cnt = load_val;
    end
    else if (s_q.cnt != W'(`CNT_ZERO))
    begin
      s_d.cnt = s_q.cnt - W'(`CNT_ONE);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign done = (s_q.cnt == W'(`CNT_ONE)) && !load;
endmodule

// ### logic/supervisor_reset_watchdog.sv
// Reset supervisor with release delay and watchdog
// What this block does
// - Manual reset low forces reset asserted
// - Hold reset for release delay after supply
// - Supply loss reasserts reset, restarts delay
// - Complementary output mirrors inverted reset
// - Push-pull default, open-drain option
// - Both kick edges restart watchdog count
// - Expiry asserts reset for full delay
// - Kick during reset latches unless non-latching or watchdog disabled
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter int unsigned DELAY_CYC    = `DELAY_LONG_CYC,
  parameter int unsigned TOUT_CYC     = `TOUT_LONG_CYC,
  parameter bit          WDOG_EN      = 1'b1,
  parameter bit          NON_LATCHING = 1'b0,
  parameter bit          OPEN_DRAIN   = 1'b0
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic supply_good,
  input  wire logic manual_reset_n,
  input  wire logic watchdog_kick_in,
  output logic      reset_out_n_o,
  output logic      reset_out_n_oe,
  output logic      reset_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    sup_state_t st;
    logic       kick_prev;
    logic       stuck;
    logic       rst_n_out;
  } core_t;

  core_t s_q;
  core_t s_d;

  logic kick_edge;
  logic dly_load;
  logic dly_done;
  logic wd_load;
  logic wd_done;

  assign kick_edge = watchdog_kick_in ^ s_q.kick_prev;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  // Delay counter reloads every cycle outside the delay state, so it always starts full
  assign dly_load = (s_q.st != ST_DELAY);
  assign wd_load  = (s_q.st != ST_RUN) || kick_edge;

  sup_counter #(.W(`CNT_W)) u_dly
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (dly_load),
    .load_val (`CNT_W'(DELAY_CYC)),
    .done     (dly_done)
  );

  sup_counter #(.W(`CNT_W)) u_wd
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (wd_load),
    .load_val (`CNT_W'(TOUT_CYC)),
    .done     (wd_done)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.kick_prev = watchdog_kick_in;
    unique case (s_q.st)
      ST_HOLD:
      begin
        s_d.st = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (dly_done && !s_q.stuck)
        begin
          s_d.st = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (WDOG_EN && wd_done)
        begin
          s_d.st = ST_DELAY;
        end
      end
      default:
      begin
        s_d.st = ST_HOLD;
      end
    endcase
    // Latching variant with watchdog enabled: a kick while reset is active keeps reset held, unless it lands in the cycle the delay finishes
    if (!NON_LATCHING && WDOG_EN && kick_edge && (s_q.st != ST_RUN))
    begin
      s_d.stuck = 1'b1;
    end
    if (!manual_reset_n || !supply_good)
    begin
      s_d.st = ST_HOLD;
    end
    s_d.rst_n_out = (s_d.st == ST_RUN);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain never drives high, so an external pull-up sets the released level
  assign reset_out_n_o  = OPEN_DRAIN ? 1'b0 : s_q.rst_n_out;
  assign reset_out_n_oe = OPEN_DRAIN ? !s_q.rst_n_out : 1'b1;
  assign reset_out      = !s_q.rst_n_out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_manual_forces_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !manual_reset_n |=> !s_q.rst_n_out) else $error("manual reset ignored");
  chk_supply_forces_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !supply_good |=> !s_q.rst_n_out) else $error("supply loss ignored");
  chk_release_needs_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.rst_n_out) |-> $past(s_q.st) == ST_DELAY && $past(dly_done))
    else $error("release without delay");
  chk_comp_output_inv: assert property (@(posedge clk) disable iff (!rst_n)
    reset_out == !s_q.rst_n_out) else $error("complement mismatch");
  chk_od_no_high: assert property (@(posedge clk) disable iff (!rst_n)
    (OPEN_DRAIN && reset_out_n_oe) |-> !reset_out_n_o) else $error("open drain drove high");
  chk_kick_reloads: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.st == ST_RUN && kick_edge) |=> !wd_done) else $error("kick did not reload");
  chk_expiry_resets: assert property (@(posedge clk) disable iff (!rst_n)
    (WDOG_EN && s_q.st == ST_RUN && wd_done && manual_reset_n && supply_good)
    |=> s_q.st == ST_DELAY) else $error("expiry without reset");
  chk_stuck_holds: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.stuck |=> !s_q.rst_n_out) else $error("latched reset released");
  chk_no_wdog_no_expiry: assert property (@(posedge clk) disable iff (!rst_n)
    (!WDOG_EN && s_q.st == ST_RUN && manual_reset_n && supply_good) |=> s_q.st == ST_RUN)
    else $error("expiry while disabled");
  cov_release: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_q.rst_n_out));
  cov_expiry: cover property (@(posedge clk) disable iff (!rst_n) s_q.st == ST_RUN && wd_done);
  cov_manual: cover property (@(posedge clk) disable iff (!rst_n)
    s_q.rst_n_out && !manual_reset_n);
endmodule

// ### sim/proc_model.sv
// Processor model that toggles the watchdog kick while out of reset
`timescale 1ns/1ps
module proc_model
(
  input  wire logic clk,
  input  wire logic kick_en,
  input  wire logic reset_out_n,
  output logic      watchdog_kick_in
);
  logic [3:0] cnt_q;
  initial
  begin
    watchdog_kick_in = 1'b0;
    cnt_q = 4'h0;
  end
  // Toggle every 10 cycles, well inside the timeout
  // Silent during reset, so the latching variant never locks up
  always @(posedge clk)
  begin
    #1;
    if (kick_en && reset_out_n)
    begin
      cnt_q = (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h0) watchdog_kick_in = ~watchdog_kick_in;
    end
  end
endmodule

// ### sim/supervisor_reset_watchdog_tb_top.sv
// Testbench for the reset supervisor
`timescale 1ns/1ps
module supervisor_reset_watchdog_tb_top;
  logic clk;
  logic rst_n;
  logic supply_good;
  logic manual_reset_n;
  logic kick_en;
  logic lt_kick;
  wire  od_o;
  wire  od_oe;
  wire  od_hi;
  wire  lt_o;
  wire  lt_oe;
  wire  lt_hi;
  wire  kick;
  wire  rst_o_n;
  wire  rst_oe;
  wire  rst_hi;
  int   num_errors;
  int   check_count;
  int   cyc;

  // Short counts keep the run brief: delay 20, timeout 50
  supervisor_reset_watchdog #(.DELAY_CYC(20), .TOUT_CYC(50)) DUT
  (
    .clk              (clk),
    .rst_n            (rst_n),
    .supply_good      (supply_good),
    .manual_reset_n   (manual_reset_n),
    .watchdog_kick_in (kick),
    .reset_out_n_o    (rst_o_n),
    .reset_out_n_oe   (rst_oe),
    .reset_out        (rst_hi)
  );
  // Open-drain copy with the watchdog left out: it must never expire
  supervisor_reset_watchdog #(.DELAY_CYC(20), .TOUT_CYC(50), .WDOG_EN(1'b0),
                              .NON_LATCHING(1'b1), .OPEN_DRAIN(1'b1)) DUT_OD
  (
    .clk              (clk),
    .rst_n            (rst_n),
    .supply_good      (supply_good),
    .manual_reset_n   (manual_reset_n),
    .watchdog_kick_in (lt_kick),
    .reset_out_n_o    (od_o),
    .reset_out_n_oe   (od_oe),
    .reset_out        (od_hi)
  );
  // Latching copy whose kick the bench toggles during reset on purpose
  supervisor_reset_watchdog #(.DELAY_CYC(20), .TOUT_CYC(50)) DUT_LT
  (
    .clk              (clk),
    .rst_n            (rst_n),
    .supply_good      (supply_good),
    .manual_reset_n   (manual_reset_n),
    .watchdog_kick_in (lt_kick),
    .reset_out_n_o    (lt_o),
    .reset_out_n_oe   (lt_oe),
    .reset_out        (lt_hi)
  );
  proc_model cpu
  (
    .clk              (clk),
    .kick_en          (kick_en),
    .reset_out_n      (rst_o_n),
    .watchdog_kick_in (kick)
  );

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One compare covers active-low, enable and complement together
  task automatic expect_rst(input string what, input logic act);
    check_count++;
    if ({rst_o_n, rst_oe, rst_hi} !== {~act, 1'b1, act})
    begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, {~act, 1'b1, act},
               {rst_o_n, rst_oe, rst_hi});
    end
  endtask

  // Open drain: data pin stays low, enable follows reset
  task automatic expect_od(input string what, input logic act);
    check_count++;
    if ({od_o, od_oe, od_hi} !== {1'b0, act, act})
    begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, {1'b0, act, act},
               {od_o, od_oe, od_hi});
    end
  endtask

  task automatic expect_lt(input string what, input logic act);
    check_count++;
    if ({lt_o, lt_oe, lt_hi} !== {~act, 1'b1, act})
    begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, {~act, 1'b1, act},
               {lt_o, lt_oe, lt_hi});
    end
  endtask

  task automatic t_latch();
    manual_reset_n = 1'b0;
    wait_cyc(2);
    lt_kick = ~lt_kick;
    wait_cyc(2);
    lt_kick = ~lt_kick;
    wait_cyc(1);
    manual_reset_n = 1'b1;
    wait_cyc(40);
    expect_rst("silent kick release", 1'b0);
    expect_od("open drain release", 1'b0);
    expect_lt("latched reset", 1'b1);
    $display("latch done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic t_power();
    supply_good = 1'b1;
    wait_cyc(10);
    expect_rst("power hold", 1'b1);
    expect_od("open drain hold", 1'b1);
    wait_cyc(30);
    expect_rst("power release", 1'b0);
    expect_od("open drain released", 1'b0);
    $display("power-up done");
  endtask

  task automatic t_manual();
    manual_reset_n = 1'b0;
    wait_cyc(2);
    expect_rst("manual assert", 1'b1);
    wait_cyc(30);
    expect_rst("manual held", 1'b1);
    manual_reset_n = 1'b1;
    wait_cyc(10);
    expect_rst("manual stretch", 1'b1);
    wait_cyc(30);
    expect_rst("manual release", 1'b0);
    $display("manual reset done");
  endtask

  task automatic t_supply();
    supply_good = 1'b0;
    wait_cyc(2);
    expect_rst("supply loss", 1'b1);
    supply_good = 1'b1;
    wait_cyc(15);
    supply_good = 1'b0;
    wait_cyc(1);
    supply_good = 1'b1;
    wait_cyc(15);
    expect_rst("delay restarted", 1'b1);
    wait_cyc(20);
    expect_rst("supply release", 1'b0);
    $display("supply loss done");
  endtask

  task automatic t_wdog();
    wait_cyc(150);
    expect_rst("kicked run", 1'b0);
    kick_en = 1'b0;
    wait_cyc(60);
    expect_rst("expiry", 1'b1);
    expect_od("disabled watchdog", 1'b0);
    kick_en = 1'b1;
    wait_cyc(30);
    expect_rst("after expiry", 1'b0);
    $display("watchdog done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run is about 450 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      summarize();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    supply_good = 1'b0;
    manual_reset_n = 1'b1;
    kick_en = 1'b1;
    lt_kick = 1'b0;
    wait_cyc(2);
    rst_n = 1'b1;
    t_power();
    t_manual();
    t_supply();
    t_wdog();
    t_latch();
    summarize();
  end
endmodule
